/* tsd_delay_timer.sv */
/*
 tsd_delay_timer: counts a delay in 100 us ticks made by a divider from the
 system clock. Assumes start is a one-cycle pulse with ticks valid beside it.
*/
`timescale 1ns/1ps
`default_nettype none
module tsd_delay_timer (
   // clock and reset
   input  wire logic  clock,
   input  wire logic  arst_n,
   // delay request
   tsd_timer_if.tmr   tif
);
   typedef struct packed {
      logic [tsd_pkg::DIV_W-1:0] div;
      logic [tsd_pkg::DLY_W-1:0] cnt;
      logic                      busy;
      logic                      done;
   } tsd_tmr_type;

   tsd_tmr_type r_reg;
   tsd_tmr_type r_next;
   logic        tick;

   assign tick     = (r_reg.div == tsd_pkg::DIV_W'(tsd_pkg::TICK_CYC - 1));
   assign tif.done = r_reg.done;
   assign tif.busy = r_reg.busy;

   always_comb begin
      r_next      = r_reg;
      r_next.done = 1'b0;
      if (r_reg.busy) begin
         r_next.div = tick ? '0 : r_reg.div + 1'b1;
      end
      // a fresh start restarts the divider so the first tick is whole
      if (tif.start) begin
         r_next.busy = 1'b1;
         r_next.cnt  = tif.ticks;
         r_next.div  = '0;
      end else if (r_reg.busy) begin
         if (r_reg.cnt == '0) begin
            r_next.busy = 1'b0;
            r_next.done = 1'b1;
         end else if (tick) begin
            r_next.cnt = r_reg.cnt - 1'b1;
         end
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end
endmodule
`default_nettype wire

/* tsd_engine_model.sv */
/*
 tsd_engine_model: stand-in for the measurement engine.
 assumes meas_start is a one-cycle pulse on the shared clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tsd_engine_model (
   // clock
   input  wire logic clock,
   // engine handshake
   input  wire logic meas_start,
   output var  logic meas_done
);
   logic [1:0] pipe_reg = 2'b00;
   // two-cycle answer, so a sample is never done in its start cycle
   always_ff @(posedge clock) begin
      pipe_reg <= {pipe_reg[0], meas_start};
   end
   assign meas_done = pipe_reg[1];
endmodule
`default_nettype wire

/* tsd_pkg.sv */
/*
 tsd_pkg: constants, offsets, codes and state type of the trigger source and
 delay block. Assumes a 40 MHz system clock and the plain register port.
*/
`default_nettype none
package tsd_pkg;
   // ------------------------------------------------------------
   // timebase
   // ------------------------------------------------------------
   localparam int CLK_MHZ  = 40;
   localparam int TICK_US  = 100;
   localparam int TICK_CYC = CLK_MHZ * TICK_US;
   localparam int DIV_W    = 12;
   localparam int DLY_W    = 26;
   localparam int CNT_W    = 16;
   // ------------------------------------------------------------
   // automatic delays in microseconds, the delay limit in seconds, and their tick counts
   // ------------------------------------------------------------
   localparam int DC_LONG_US  = 1500;
   localparam int DC_SHORT_US = 1000;
   localparam int RES_MID_US  = 10000;
   localparam int RES_HI_US   = 100000;
   localparam int AC_SLOW_US  = 7000000;
   localparam int AC_MED_US   = 1000000;
   localparam int AC_FAST_US  = 600000;
   localparam int FREQ_US     = 1000000;
   localparam int DLY_MAX_S   = 3600;
   localparam logic [DLY_W-1:0] DC_LONG_T  = DLY_W'(DC_LONG_US / TICK_US);
   localparam logic [DLY_W-1:0] DC_SHORT_T = DLY_W'(DC_SHORT_US / TICK_US);
   localparam logic [DLY_W-1:0] RES_MID_T  = DLY_W'(RES_MID_US / TICK_US);
   localparam logic [DLY_W-1:0] RES_HI_T   = DLY_W'(RES_HI_US / TICK_US);
   localparam logic [DLY_W-1:0] AC_SLOW_T  = DLY_W'(AC_SLOW_US / TICK_US);
   localparam logic [DLY_W-1:0] AC_MED_T   = DLY_W'(AC_MED_US / TICK_US);
   localparam logic [DLY_W-1:0] AC_FAST_T  = DLY_W'(AC_FAST_US / TICK_US);
   localparam logic [DLY_W-1:0] FREQ_T     = DLY_W'(FREQ_US / TICK_US);
   localparam logic [DLY_W-1:0] DLY_MAX_T  = DLY_W'(DLY_MAX_S * (1000000 / TICK_US));
   // ------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_AUTO   = 8'h00;
   localparam logic [7:0] OFS_SRC    = 8'h04;
   localparam logic [7:0] OFS_DLY    = 8'h08;
   localparam logic [7:0] OFS_TCNT   = 8'h0C;
   localparam logic [7:0] OFS_SCNT   = 8'h10;
   localparam logic [7:0] OFS_MCFG   = 8'h14;
   localparam logic [7:0] OFS_CMD    = 8'h18;
   localparam logic [7:0] OFS_STAT   = 8'h1C;
   // ------------------------------------------------------------
   // fields, codes, reset values
   // ------------------------------------------------------------
   localparam int CMD_ARM   = 0;
   localparam int CMD_BUS   = 1;
   localparam int CMD_CFG   = 2;
   localparam int CMD_MEAS  = 3;
   localparam int CMD_ARMRD = 4;
   localparam int CMD_ABORT = 5;
   localparam int STA_IGN   = 3;
   localparam logic [3:0] SRC_BUS = 4'h8;
   localparam logic [3:0] SRC_EXT = 4'h9;
   localparam logic [3:0] SRC_IMM = 4'hA;
   localparam logic [2:0] FN_DCV  = 3'h0;
   localparam logic [2:0] FN_DCI  = 3'h1;
   localparam logic [2:0] FN_RES2 = 3'h2;
   localparam logic [2:0] FN_RES4 = 3'h3;
   localparam logic [2:0] FN_ACV  = 3'h4;
   localparam logic [2:0] FN_ACI  = 3'h5;
   localparam logic [2:0] RNG_1M  = 3'h4;
   localparam logic [1:0] FLT_SLOW = 2'h0;
   localparam logic [1:0] FLT_MED  = 2'h1;
   localparam logic [CNT_W-1:0] TRIG_MAX = 16'hC350;
   localparam logic [CNT_W-1:0] CNT_RST  = 16'h0001;
   localparam logic             AUTO_RST = 1'b1;
   typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_DELAY, ST_MEAS} tsd_state_type;
endpackage
`default_nettype wire

/* tsd_timer_if.sv */
/*
 tsd_timer_if: start, length and completion of one delay between the
 trigger controller and its delay timer. Both ends share one clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface tsd_timer_if;
   logic                    start;
   logic [tsd_pkg::DLY_W-1:0] ticks;
   logic                    done;
   logic                    busy;
   modport ctl (output start, output ticks, input done, input busy);
   modport tmr (input start, input ticks, output done, output busy);
endinterface
`default_nettype wire

/* tsd_trigger_ctrl.sv */
/*
 tsd_trigger_ctrl: trigger source selection, arming, trigger counting and
 trigger-to-measurement delay, manual or automatic. Assumes a measurement
 engine that answers each start pulse with a done pulse, and a register
 master that keeps strobes one cycle long and never both at once.
*/
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module tsd_trigger_ctrl (
   // clock and reset
   input  wire logic        clock,
   input  wire logic        arst_n,
   // register port
   input  wire logic [7:0]  addr,
   input  wire logic [31:0] wr_data,
   input  wire logic        wr_en,
   input  wire logic        rd_en,
   output var  logic [31:0] rd_data,
   // trigger inputs
   input  wire logic        ext_trig,
   input  wire logic [7:0]  bp_trig,
   // measurement engine
   input  wire logic        meas_done,
   output var  logic        meas_start,
   output var  logic        waiting,
   output var  logic        trig_ignored
);
   typedef struct packed {
      tsd_pkg::tsd_state_type          st;
      logic                            auto_en;
      logic [3:0]                      src;
      logic [tsd_pkg::DLY_W-1:0]       dly;
      logic [tsd_pkg::CNT_W-1:0]       tcnt;
      logic [tsd_pkg::CNT_W-1:0]       scnt;
      logic [2:0]                      fn;
      logic [2:0]                      rng;
      logic                            lng;
      logic [1:0]                      flt;
      logic [tsd_pkg::CNT_W-1:0]       tleft;
      logic [tsd_pkg::CNT_W-1:0]       sleft;
      logic                            ign_flag;
      logic                            ign;
      logic                            mstart;
      logic                            tstart;
      logic                            wait_q;
      logic [tsd_pkg::DLY_W-1:0]       tticks;
      logic [31:0]                     rdata;
      logic [2:0]                      ext_s;
      logic [7:0]                      bp_s1;
      logic [7:0]                      bp_s2;
      logic [7:0]                      bp_s3;
   } tsd_ctrl_type;

   tsd_ctrl_type r_reg;
   tsd_ctrl_type r_next;
   tsd_timer_if  tif ();

   tsd_delay_timer u_timer (
      .clock  (clock),
      .arst_n (arst_n),
      .tif    (tif)
   );

   // ------------------------------------------------------------
   // automatic delay table
   // ------------------------------------------------------------
   function automatic logic [tsd_pkg::DLY_W-1:0] auto_ticks(
      input logic [2:0] fn,
      input logic [2:0] rng,
      input logic       lng,
      input logic [1:0] flt
   );
      logic [tsd_pkg::DLY_W-1:0] t;
      t = tsd_pkg::FREQ_T;
      case (fn)
         tsd_pkg::FN_DCV, tsd_pkg::FN_DCI: begin
            t = lng ? tsd_pkg::DC_LONG_T : tsd_pkg::DC_SHORT_T;
         end
         tsd_pkg::FN_RES2, tsd_pkg::FN_RES4: begin
            if (rng < tsd_pkg::RNG_1M) begin
               t = lng ? tsd_pkg::DC_LONG_T : tsd_pkg::DC_SHORT_T;
            end else if (rng == tsd_pkg::RNG_1M) begin
               t = lng ? tsd_pkg::DC_LONG_T : tsd_pkg::RES_MID_T;
            end else begin
               t = tsd_pkg::RES_HI_T;
            end
         end
         tsd_pkg::FN_ACV, tsd_pkg::FN_ACI: begin
            case (flt)
               tsd_pkg::FLT_SLOW: t = tsd_pkg::AC_SLOW_T;
               tsd_pkg::FLT_MED:  t = tsd_pkg::AC_MED_T;
               default:           t = tsd_pkg::AC_FAST_T;
            endcase
         end
         default: t = tsd_pkg::FREQ_T;
      endcase
      return t;
   endfunction

   // ------------------------------------------------------------
   // control
   // ------------------------------------------------------------
   logic                      wr_cmd;
   logic                      bus_trg;
   logic                      hit;
   logic                      arm;
   logic [tsd_pkg::DLY_W-1:0] cur_dly;

   assign wr_cmd  = wr_en && (addr == tsd_pkg::OFS_CMD);
   assign bus_trg = wr_cmd && wr_data[tsd_pkg::CMD_BUS];
   assign cur_dly = r_reg.auto_en ? auto_ticks(r_reg.fn, r_reg.rng, r_reg.lng, r_reg.flt)
                                  : r_reg.dly;

   always_comb begin
      r_next        = r_reg;
      r_next.mstart = 1'b0;
      r_next.tstart = 1'b0;
      r_next.ign    = 1'b0;
      r_next.rdata  = '0;
      // sync stage one feeds stage two only
      r_next.ext_s  = {r_reg.ext_s[1:0], ext_trig};
      r_next.bp_s1  = bp_trig;
      r_next.bp_s2  = r_reg.bp_s1;
      r_next.bp_s3  = r_reg.bp_s2;

      // only the selected source is looked at
      case (r_reg.src)
         tsd_pkg::SRC_BUS: hit = bus_trg;
         tsd_pkg::SRC_EXT: hit = r_reg.ext_s[2] & ~r_reg.ext_s[1];
         tsd_pkg::SRC_IMM: hit = 1'b1;
         default: hit = r_reg.bp_s3[r_reg.src[2:0]] & ~r_reg.bp_s2[r_reg.src[2:0]];
      endcase

      // register writes
      if (wr_en) begin
         case (addr)
            tsd_pkg::OFS_AUTO: begin
               if (wr_data[31:1] == '0) begin
                  r_next.auto_en = wr_data[0];
               end
            end
            tsd_pkg::OFS_SRC: begin
               // selecting a source never arms
               if (wr_data[31:4] == '0 && wr_data[3:0] <= tsd_pkg::SRC_IMM) begin
                  r_next.src = wr_data[3:0];
               end
            end
            tsd_pkg::OFS_DLY: begin
               r_next.auto_en = 1'b0;
               r_next.dly = (wr_data > 32'(tsd_pkg::DLY_MAX_T)) ? tsd_pkg::DLY_MAX_T
                                                               : wr_data[tsd_pkg::DLY_W-1:0];
            end
            tsd_pkg::OFS_TCNT: begin
               if (wr_data == '0) begin
                  r_next.tcnt = tsd_pkg::CNT_RST;
               end else if (wr_data > 32'(tsd_pkg::TRIG_MAX)) begin
                  r_next.tcnt = tsd_pkg::TRIG_MAX;
               end else begin
                  r_next.tcnt = wr_data[tsd_pkg::CNT_W-1:0];
               end
            end
            tsd_pkg::OFS_SCNT: begin
               r_next.scnt = (wr_data[15:0] == '0) ? tsd_pkg::CNT_RST : wr_data[15:0];
            end
            tsd_pkg::OFS_MCFG: begin
               r_next.fn  = wr_data[2:0];
               r_next.rng = wr_data[6:4];
               r_next.lng = wr_data[8];
               r_next.flt = wr_data[13:12];
            end
            tsd_pkg::OFS_CMD: begin
               if (wr_data[tsd_pkg::CMD_CFG] || wr_data[tsd_pkg::CMD_MEAS]) begin
                  r_next.src  = tsd_pkg::SRC_IMM;
                  r_next.tcnt = tsd_pkg::CNT_RST;
               end
            end
            default: ;
         endcase
      end

      // bus trigger outside the wait state is dropped and flagged
      if (bus_trg && r_reg.st != tsd_pkg::ST_WAIT) begin
         r_next.ign = 1'b1;
      end
      // set wins over a same-cycle clear
      if (wr_en && addr == tsd_pkg::OFS_STAT && wr_data[tsd_pkg::STA_IGN]) begin
         r_next.ign_flag = 1'b0;
      end
      if (r_next.ign) begin
         r_next.ign_flag = 1'b1;
      end

      arm = wr_cmd && (wr_data[tsd_pkg::CMD_ARM] || wr_data[tsd_pkg::CMD_ARMRD]
                       || wr_data[tsd_pkg::CMD_MEAS]);

      // ------------------------------------------------------------
      // sequence
      // ------------------------------------------------------------
      case (r_reg.st)
         tsd_pkg::ST_IDLE: begin
            if (arm) begin
               r_next.st    = tsd_pkg::ST_WAIT;
               r_next.tleft = r_next.tcnt;
               r_next.sleft = r_reg.scnt;
            end
         end
         tsd_pkg::ST_WAIT: begin
            if (hit) begin
               r_next.st     = tsd_pkg::ST_DELAY;
               r_next.tstart = 1'b1;
               r_next.tticks = cur_dly;
            end
         end
         tsd_pkg::ST_DELAY: begin
            if (tif.done) begin
               r_next.st     = tsd_pkg::ST_MEAS;
               r_next.mstart = 1'b1;
            end
         end
         tsd_pkg::ST_MEAS: begin
            if (meas_done) begin
               if (r_reg.sleft > 16'h0001) begin
                  r_next.sleft  = r_reg.sleft - 1'b1;
                  r_next.st     = tsd_pkg::ST_DELAY;
                  r_next.tstart = 1'b1;
                  r_next.tticks = cur_dly;
               end else if (r_reg.tleft > 16'h0001) begin
                  r_next.tleft = r_reg.tleft - 1'b1;
                  r_next.sleft = r_reg.scnt;
                  r_next.st    = tsd_pkg::ST_WAIT;
               end else begin
                  r_next.st = tsd_pkg::ST_IDLE;
               end
            end
         end
         default: r_next.st = tsd_pkg::ST_IDLE;
      endcase

      // abort overrides the state and both start pulses; a delay in flight finishes unseen
      if (wr_cmd && wr_data[tsd_pkg::CMD_ABORT]) begin
         r_next.st     = tsd_pkg::ST_IDLE;
         r_next.mstart = 1'b0;
         r_next.tstart = 1'b0;
      end

      // waiting leaves a flop, in step with the state
      r_next.wait_q = (r_next.st == tsd_pkg::ST_WAIT);

      // reads: answer one cycle later, zero for unmapped offsets
      if (rd_en) begin
         case (addr)
            tsd_pkg::OFS_AUTO: r_next.rdata = {31'h0000_0000, r_reg.auto_en};
            tsd_pkg::OFS_SRC:  r_next.rdata = {28'h000_0000, r_reg.src};
            tsd_pkg::OFS_DLY:  r_next.rdata = {6'h00, r_reg.dly};
            tsd_pkg::OFS_TCNT: r_next.rdata = {16'h0000, r_reg.tcnt};
            tsd_pkg::OFS_SCNT: r_next.rdata = {16'h0000, r_reg.scnt};
            tsd_pkg::OFS_MCFG: r_next.rdata = {18'h0_0000, r_reg.flt, 3'h0, r_reg.lng,
                                               1'b0, r_reg.rng, 1'b0, r_reg.fn};
            tsd_pkg::OFS_STAT: r_next.rdata = {r_reg.tleft, 12'h000, r_reg.ign_flag,
                                               r_reg.st == tsd_pkg::ST_MEAS,
                                               r_reg.st == tsd_pkg::ST_DELAY,
                                               r_reg.st == tsd_pkg::ST_WAIT};
            default:           r_next.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         r_reg         <= '0;
         r_reg.st      <= tsd_pkg::ST_IDLE;
         r_reg.auto_en <= tsd_pkg::AUTO_RST;
         r_reg.src     <= tsd_pkg::SRC_IMM;
         r_reg.tcnt    <= tsd_pkg::CNT_RST;
         r_reg.scnt    <= tsd_pkg::CNT_RST;
         r_reg.ext_s   <= 3'h7;
         r_reg.bp_s1   <= 8'hFF;
         r_reg.bp_s2   <= 8'hFF;
         r_reg.bp_s3   <= 8'hFF;
      end else begin
         r_reg <= r_next;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign tif.start    = r_reg.tstart;
   assign tif.ticks    = r_reg.tticks;
   assign rd_data      = r_reg.rdata;
   assign meas_start   = r_reg.mstart;
   assign waiting      = r_reg.wait_q;
   assign trig_ignored = r_reg.ign;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);

   sequence s_ext_fall;
      waiting && r_reg.src == tsd_pkg::SRC_EXT && r_reg.ext_s[2] && !r_reg.ext_s[1];
   endsequence
   sequence s_delay_end;
      r_reg.st == tsd_pkg::ST_DELAY && tif.done && !wr_cmd;
   endsequence

   a_ext_fall_fires: assert property (s_ext_fall and !wr_cmd |=> r_reg.st == tsd_pkg::ST_DELAY ##1
      tif.busy) else $error("external fall did not start delay");
   a_imm_fires_now: assert property (waiting && r_reg.src == tsd_pkg::SRC_IMM && !wr_cmd |=>
      r_reg.tstart) else $error("always_true_source source did not fire");
   a_bus_trg_ign: assert property (bus_trg && !waiting |=> trig_ignored && r_reg.ign_flag)
      else $error("bus trigger outside wait not flagged");
   a_dly_wr_clear: assert property (wr_en && addr == tsd_pkg::OFS_DLY |=> !r_reg.auto_en)
      else $error("delay write left automatic on");
   a_auto_rdback: assert property (rd_en && addr == tsd_pkg::OFS_AUTO |=>
      rd_data == {31'h0000_0000, $past(r_reg.auto_en)}) else $error("enable readback wrong");
   a_cfg_forces_imm: assert property (wr_cmd && wr_data[tsd_pkg::CMD_CFG] |=>
      r_reg.src == tsd_pkg::SRC_IMM && r_reg.tcnt == 16'h0001) else $error("command_b kept src");
   a_start_after_dly: assert property (s_delay_end |=> meas_start && r_reg.st == tsd_pkg::ST_MEAS)
      else $error("no measurement start after delay");
   a_count_bounds: assert property (r_reg.tcnt != '0 && r_reg.tcnt <= tsd_pkg::TRIG_MAX)
      else $error("trigger count out of range");
   a_src_no_arm: assert property (r_reg.st == tsd_pkg::ST_IDLE && !wr_cmd |=>
      r_reg.st == tsd_pkg::ST_IDLE) else $error("left idle without arm");
endmodule
`default_nettype wire

/* tsd_trigger_ctrl_tb_top.sv */
/*
 tsd_trigger_ctrl_tb_top: self-checking bench of the trigger controller.
 assumes tsd_pkg, the delay timer and the engine model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tsd_trigger_ctrl_tb_top;
   logic        clock    = 1'b0;
   logic        arst_n   = 1'b0;
   logic [7:0]  addr     = 8'h00;
   logic [31:0] wr_data  = 32'h0000_0000;
   logic        wr_en    = 1'b0;
   logic        rd_en    = 1'b0;
   logic        ext_trig = 1'b1;
   logic [7:0]  bp_trig  = 8'hFF;
   logic [31:0] rd_data;
   logic        meas_done;
   logic        meas_start;
   logic        waiting;
   logic        trig_ignored;
   int          bad_count = 0;
   int          n_tests   = 0;
   int          n_ign     = 0;
   int          n_start   = 0;
   int          snap;
   always #12.5 clock = ~clock;
   tsd_trigger_ctrl i_dut (.clock(clock), .arst_n(arst_n), .addr(addr), .wr_data(wr_data),
      .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .ext_trig(ext_trig), .bp_trig(bp_trig),
      .meas_done(meas_done), .meas_start(meas_start), .waiting(waiting),
      .trig_ignored(trig_ignored));
   tsd_engine_model i_eng (.clock(clock), .meas_start(meas_start), .meas_done(meas_done));
   // pulses counted mid-cycle, where they have settled
   always @(negedge clock) begin
      if (trig_ignored === 1'b1) n_ign++;
      if (meas_start === 1'b1) n_start++;
   end
   // ------------------------------------------------------------
   // bus and compare tasks
   // ------------------------------------------------------------
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic check_val(string nm, logic [31:0] exp, logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [31:0] d);
      @(posedge clock);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge clock);
      wr_en <= 1'b0;
   endtask
   task automatic rd_chk(string nm, logic [7:0] a, logic [31:0] msk, logic [31:0] exp);
      @(posedge clock);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clock);
      rd_en <= 1'b0;
      #1 check_val(nm, exp, rd_data & msk);
   endtask
   // start cycles counted from the clock edge on which the task is called
   task automatic wait_start(string nm, int lo, int hi);
      int n;
      n = 0;
      while (meas_start !== 1'b1) begin
         @(posedge clock);
         #1 n++;
         if (n > hi) begin
            check_val(nm, 1, 0);
            complete_run();
         end
      end
      n_tests++;
      if (n < lo) begin
         bad_count++;
         $display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, n);
      end
      repeat (6) @(posedge clock);
   endtask
   task automatic no_start(string nm);
      repeat (8) @(posedge clock);
      check_val(nm, snap, n_start);
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_regs();
      rd_chk("auto rst", 8'h00, 1, 1);
      rd_chk("src rst", 8'h04, 15, 10);
      rd_chk("tcnt rst", 8'h0C, 32'hFFFF, 1);
      rd_chk("unmapped", 8'hFC, 32'hFFFF_FFFF, 0);
      wr(8'h08, 0);
      rd_chk("auto off", 8'h00, 1, 0);
      wr(8'h00, 1);
      wr(8'h00, 2);
      rd_chk("auto on", 8'h00, 32'hFFFF_FFFF, 1);
      wr(8'h00, 0);
      rd_chk("auto zero", 8'h00, 32'hFFFF_FFFF, 0);
      wr(8'h0C, 70000);
      rd_chk("tcnt max", 8'h0C, 32'hFFFF, 50000);
      wr(8'h0C, 0);
      rd_chk("tcnt min", 8'h0C, 32'hFFFF, 1);
   endtask
   task automatic t_bus();
      wr(8'h04, 8);
      rd_chk("src bus", 8'h04, 15, 8);
      #1 check_val("no arm", 0, waiting);
      wr(8'h18, 2);
      repeat (3) @(posedge clock);
      check_val("ignored", 1, n_ign);
      rd_chk("sticky", 8'h1C, 8, 8);
      wr(8'h1C, 8);
      wr(8'h18, 1);
      #1 check_val("armed", 1, waiting);
      wr(8'h18, 2);
      wait_start("bus start", 1, 10);
      check_val("not ignored", 1, n_ign);
   endtask
   task automatic t_ext();
      wr(8'h04, 9);
      ext_trig <= 1'b0;
      // let the early fall clear the synchroniser before arming
      repeat (4) @(posedge clock);
      wr(8'h18, 1);
      snap = n_start;
      ext_trig <= 1'b1;
      bp_trig <= 8'h00;
      no_start("ext rise");
      bp_trig <= 8'hFF;
      ext_trig <= 1'b0;
      wait_start("ext fall", 3, 12);
      ext_trig <= 1'b1;
   endtask
   task automatic t_line();
      wr(8'h04, 3);
      wr(8'h18, 1);
      snap = n_start;
      bp_trig <= 8'hFB;
      ext_trig <= 1'b0;
      no_start("other line");
      ext_trig <= 1'b1;
      bp_trig <= 8'hF7;
      wait_start("line 3", 3, 12);
      bp_trig <= 8'hFF;
   endtask
   task automatic t_samples();
      wr(8'h04, 10);
      wr(8'h10, 2);
      wr(8'h08, 2);
      wr(8'h18, 1);
      wait_start("first delay", 4000, 8010);
      wait_start("sample gap", 3990, 8010);
      wr(8'h10, 1);
   endtask
   task automatic t_config();
      wr(8'h04, 8);
      wr(8'h0C, 5);
      wr(8'h18, 4);
      rd_chk("cfg src", 8'h04, 15, 10);
      rd_chk("cfg tcnt", 8'h0C, 32'hFFFF, 1);
   endtask
   task automatic t_auto();
      // dc voltage, short integration: 1.0 ms at 40 cycles per us
      wr(8'h14, 0);
      wr(8'h00, 1);
      wr(8'h18, 1);
      wait_start("dc auto", 36000, 40010);
   endtask
   task automatic t_cmds();
      wr(8'h08, 0);
      wr(8'h04, 8);
      wr(8'h18, 1);
      #1 check_val("armed bus", 1, waiting);
      wr(8'h18, 32);
      #1 check_val("abort", 0, waiting);
      snap = n_ign;
      wr(8'h18, 2);
      repeat (3) @(posedge clock);
      check_val("ign after abort", snap + 1, n_ign);
      wr(8'h0C, 5);
      wr(8'h18, 8);
      wait_start("command_a", 3, 12);
      rd_chk("meas src", 8'h04, 15, 10);
      rd_chk("meas tcnt", 8'h0C, 32'hFFFF, 1);
      wr(8'h18, 16);
      wait_start("arm read", 3, 12);
   endtask
   initial begin
      repeat (20) @(posedge clock);
      arst_n <= 1'b1;
      t_regs();
      t_bus();
      t_ext();
      t_line();
      t_samples();
      t_config();
      t_auto();
      t_cmds();
      complete_run();
   end
endmodule
`default_nettype wire
